/* verilog/sci_rx_defines.svh */
`ifndef SCI_RX_DEFINES_SVH
`define SCI_RX_DEFINES_SVH
// Register byte addresses on the Avalon-MM slave (word aligned)
`define ADDR_STATUS 4'h0
`define ADDR_DATA 4'h4
`define ADDR_CTRL 4'h8
`define ADDR_BAUD 4'hC
// Status register bit positions
`define ST_FULL 5
`define ST_OVR 3
`define ST_NOISE 2
`define ST_FRAME 1
// Control register bit positions
`define CT_RIE 5
`define CT_GMASK 0
// Reset values
`define CTRL_RST 8'h01
`define BAUD_RST 16'h0036
// Oversampling: sixteen samples a bit, majority taken at samples 8, 9, 10
`define OVS_LAST 4'hF
`define SMP_A 4'h7
`define SMP_B 4'h8
`define SMP_C 4'h9
`define DATA_BITS 4'h8
`endif

/* verilog/sci_rx_pkg.sv */
package sci_rx_pkg;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_e;
  typedef logic [7:0] byte_t;
endpackage

/* verilog/sci_receive_error_detect.sv */
`timescale 1ns/100ps
`include "sci_rx_defines.svh"
module sci_receive_error_detect (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rx,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_irq
);

  // Bus slave: one wait cycle, answer on the second edge of a request
  logic ack_q;
  logic [31:0] rdata_q;
  wire req = i_read | i_write;
  wire take = req & ack_q;
  wire hit_status = (i_address == `ADDR_STATUS);
  wire hit_data = (i_address == `ADDR_DATA);
  wire hit_ctrl = (i_address == `ADDR_CTRL);
  wire hit_baud = (i_address == `ADDR_BAUD);
  wire rd_status = take & i_read & hit_status;
  wire rd_data = take & i_read & hit_data;
  wire wr_ctrl = take & i_write & hit_ctrl;
  wire wr_baud = take & i_write & hit_baud;

  // Waitrequest idles high and drops only for the cycle in which a request is taken
  logic wait_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= req & ~ack_q;
      wait_q <= ~(req & ~ack_q);
    end
  end
  assign o_waitrequest = wait_q;

  // Control and baud registers
  logic [7:0] ctrl_q;
  logic [15:0] baud_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `CTRL_RST;
      baud_q <= `BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_writedata[7:0];
      end
      if (wr_baud) begin
        baud_q <= i_writedata[15:0];
      end
    end
  end
  wire rx_irq_enable = ctrl_q[`CT_RIE];
  wire global_mask = ctrl_q[`CT_GMASK];

  // Sixteen-times oversampling tick
  logic [15:0] div_q;
  logic tick_q;
  // A divisor written below the running count ends the count at once, no wrap
  wire div_end = (div_q >= baud_q);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
      tick_q <= div_end;
    end
  end

  // Receive state machine
  sci_rx_pkg::rx_state_e state_q;
  logic [3:0] smp_q;
  logic [3:0] bit_q;
  logic [2:0] maj_q;
  logic [7:0] shift_q;
  logic line_q;
  logic frame_noise_q;
  logic hidden_noise_q;
  logic done_q;
  logic done_fe_q;
  logic done_nf_q;
  wire fall = line_q & ~i_rx;
  wire agree = (maj_q == 3'b000) | (maj_q == 3'b111);
  wire maj_bit = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2]) | (maj_q[0] & maj_q[2]);
  wire at_c = (smp_q == `SMP_C);
  wire bit_end = (smp_q == `OVS_LAST);
  wire in_window = (smp_q == `SMP_A) | (smp_q == `SMP_B) | at_c;
  // The three mid-bit samples as they stand on the tenth sample
  wire [2:0] trio = {maj_q[1:0], i_rx};
  wire start_bad = (trio != 3'b000);
  wire stop_low = ~(trio[2] & trio[1]) & ~(trio[1] & trio[0]) & ~(trio[2] & trio[0]);
  wire trio_noise = (trio != 3'b111) & (trio != 3'b000);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= sci_rx_pkg::RX_IDLE;
      smp_q <= 4'h0;
      bit_q <= 4'h0;
      maj_q <= 3'b000;
      shift_q <= 8'h00;
      line_q <= 1'b1;
      frame_noise_q <= 1'b0;
      hidden_noise_q <= 1'b0;
      done_q <= 1'b0;
      done_fe_q <= 1'b0;
      done_nf_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tick_q) begin
        line_q <= i_rx;
        smp_q <= smp_q + 4'h1;
        if (in_window) begin
          maj_q <= {maj_q[1:0], i_rx};
        end
        case (state_q)
          sci_rx_pkg::RX_IDLE: begin
            smp_q <= 4'h1;
            if (fall) begin
              state_q <= sci_rx_pkg::RX_START;
              frame_noise_q <= 1'b0;
            end
          end
          sci_rx_pkg::RX_START: begin
            if (at_c) begin
              if (start_bad) begin
                // False start: discard, remember noise
                state_q <= sci_rx_pkg::RX_IDLE;
                hidden_noise_q <= 1'b1;
              end
            end else if (bit_end) begin
              state_q <= sci_rx_pkg::RX_DATA;
              bit_q <= 4'h0;
            end
          end
          sci_rx_pkg::RX_DATA: begin
            if (bit_end) begin
              shift_q <= {maj_bit, shift_q[7:1]};
              if (!agree) begin
                frame_noise_q <= 1'b1;
              end
              bit_q <= bit_q + 4'h1;
              if (bit_q == `DATA_BITS - 4'h1) begin
                state_q <= sci_rx_pkg::RX_STOP;
              end
            end
          end
          default: begin
            if (at_c) begin
              state_q <= sci_rx_pkg::RX_IDLE;
              done_q <= 1'b1;
              // Stop bit low by majority, including a break
              done_fe_q <= stop_low;
              done_nf_q <= frame_noise_q | hidden_noise_q | trio_noise;
              hidden_noise_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Holding register, flags and two-step clear
  logic [7:0] hold_q;
  logic full_q;
  logic ovr_q;
  logic nf_q;
  logic fe_q;
  logic armed_q;
  logic irq_q;
  wire clr_seq = rd_data & armed_q;

  // Two-entry buffer between frame assembly and the flag stage; the flag stage
  // stalls on the clearing data read so a frame finishing then is not lost
  logic [1:0] buf_cnt_q;
  logic buf_wr_q;
  logic buf_rd_q;
  wire [9:0] buf_w [2];
  wire [9:0] in_word = {done_nf_q, done_fe_q, shift_q};
  wire in_valid = done_q;
  wire in_ready = (buf_cnt_q != 2'b10);
  wire out_valid = (buf_cnt_q != 2'b00);
  wire out_ready = ~clr_seq;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [9:0] out_word = buf_rd_q ? buf_w[1] : buf_w[0];

  for (genvar g = 0; g < 2; g++) begin : g_entry
    logic [9:0] word_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        word_q <= 10'h000;
      end else if (push & (buf_wr_q == 1'(g))) begin
        word_q <= in_word;
      end
    end
    assign buf_w[g] = word_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_cnt_q <= 2'b00;
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
    end else begin
      if (push) begin
        buf_wr_q <= ~buf_wr_q;
      end
      if (pop) begin
        buf_rd_q <= ~buf_rd_q;
      end
      if (push & ~pop) begin
        buf_cnt_q <= buf_cnt_q + 2'b01;
      end else if (pop & ~push) begin
        buf_cnt_q <= buf_cnt_q - 2'b01;
      end
    end
  end

  wire overrun = pop & full_q & ~rd_data;
  wire load = pop & ~overrun;
  wire irq_d = rx_irq_enable & ~global_mask & (full_q | ovr_q);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed_q <= 1'b0;
    end else if (rd_status) begin
      armed_q <= 1'b1;
    end else if (rd_data) begin
      armed_q <= 1'b0;
    end
  end

  // No frame loads in the clearing cycle; the buffer holds it until after the clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 8'h00;
      full_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
    end else if (load) begin
      hold_q <= out_word[7:0];
      full_q <= 1'b1;
      nf_q <= out_word[9];
      fe_q <= out_word[8];
    end else if (clr_seq) begin
      full_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
    end
  end

  // Overrun and the clear never fall in the same cycle; a data read blocks the overrun
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (overrun) begin
        ovr_q <= 1'b1;
      end else if (clr_seq) begin
        ovr_q <= 1'b0;
      end
      irq_q <= irq_d;
    end
  end
  assign o_irq = irq_q;

  wire [7:0] status_w = {2'b00, full_q, 1'b0, ovr_q, nf_q, fe_q, 1'b0};
  wire [7:0] sel_w = hit_status ? status_w :
                     hit_data ? hold_q :
                     hit_ctrl ? ctrl_q : 8'h00;
  wire [31:0] rd_w = hit_baud ? {16'h0000, baud_q} : {24'h00_0000, sel_w};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= (req & ~ack_q & i_read) ? rd_w : rdata_q;
    end
  end
  assign o_readdata = rdata_q;

endmodule

/* verif/sci_rx_sva.sv */
`timescale 1ns/100ps
module sci_rx_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rx,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_irq
);
  wire logic rd_ok = i_read && !o_waitrequest;
  wire logic st_rd = rd_ok && i_address == 4'h0;
  wire logic ctl_wr = i_write && !o_waitrequest && i_address == 4'h8;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_wait_first: assert property ($rose(i_read || i_write) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("wait state wrong");
  a_wait_bound: assert property ((i_read || i_write) |-> ##[0:1] !o_waitrequest)
    else $error("no answer");
  a_unmap_zero: assert property (rd_ok && i_address[1:0] != 2'h0 |-> o_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_stat_bits: assert property (st_rd |-> (o_readdata & 32'hFFFF_FFD1) == 32'h0000_0000)
    else $error("stray status bit");
  a_err_full: assert property (st_rd && o_readdata[3:1] != 3'h0 |-> o_readdata[5])
    else $error("error flag without full");
  a_data_byte: assert property (rd_ok && i_address == 4'h4 |-> o_readdata[31:8] == 24'h00_0000)
    else $error("data upper bits set");
  a_rdata_hold: assert property (!i_read |=> $stable(o_readdata))
    else $error("read data moved");
  a_irq_fall: assert property ($fell(o_irq) |-> $past(rd_ok && i_address == 4'h4, 2) || $past(ctl_wr, 2))
    else $error("irq fell without cause");
  c_ovr: cover property (st_rd && o_readdata[3]);
  c_noise: cover property (st_rd && o_readdata[2]);
  c_frame: cover property (st_rd && o_readdata[1]);
  c_irq: cover property ($rose(o_irq));
endmodule
bind sci_receive_error_detect sci_rx_sva sci_rx_sva_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_rx(i_rx), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_irq(o_irq));

/* verif/sci_tx_model.sv */
`timescale 1ns/100ps
module sci_tx_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_byte,
  input wire logic [1:0] i_mode,
  output logic o_rx,
  output logic o_busy
);
  // Sixteen clocks a bit; flip puts one wrong sample at offset 8
  task automatic bit_out(input logic v, input int flip);
    for (int k = 0; k < 16; k++) begin
      o_rx <= (k == flip) ? !v : v;
      @(posedge i_clk);
    end
  endtask
  initial begin
    o_rx = 1'b1;
    o_busy = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      if (i_mode == 2'h2) begin
        // Short low pulse gives samples 0,1,1
        repeat (8) begin
          o_rx <= 1'b0;
          @(posedge i_clk);
        end
        bit_out(1'b1, -1);
      end
      bit_out(1'b0, -1);
      for (int i = 0; i < 8; i++) bit_out(i_byte[i], (i == 0 && i_mode == 2'h1) ? 8 : -1);
      bit_out(i_mode != 2'h3, -1);
      o_rx <= 1'b1;
      o_busy <= 1'b0;
    end
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx, irq, wt, bsy, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, q, rdat;
  logic [7:0] byt = 8'h00;
  logic [1:0] md = 2'h0;
  logic [7:0] tb_b [5] = '{8'hA5, 8'h5A, 8'h81, 8'h00, 8'h3C};
  logic [31:0] tb_s [5] = '{32'h0000_0020, 32'h0000_0024, 32'h0000_0024, 32'h0000_0022,
    32'h0000_0028};
  int fails = 0, checks = 0, cyc = 0;
  always #5 clk = !clk;
  sci_receive_error_detect sci_receive_error_detect_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_rx(rx), .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd),
    .o_readdata(rdat), .o_waitrequest(wt), .o_irq(irq));
  sci_tx_model sci_tx_model_i (.i_clk(clk), .i_go(go), .i_byte(byt), .i_mode(md),
    .o_rx(rx), .o_busy(bsy));
  task automatic summarize();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(input logic [7:0] b, input logic [1:0] m);
    byt <= b;
    md <= m;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (bsy) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h8, 32'h0000_0000);
    check(q, 32'h0000_0001);
    bus(1'b0, 4'hC, 32'h0000_0000);
    check(q, 32'h0000_0036);
    bus(1'b0, 4'h1, 32'h0000_0000);
    check(q, 32'h0000_0000);
    bus(1'b1, 4'hC, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'h0000_0020);
    for (int i = 0; i < 5; i++) begin
      send(tb_b[i], (i == 4) ? 2'h0 : 2'(i));
      if (i == 4) send(8'hC3, 2'h0);
      check(32'(irq), 32'h0000_0001);
      bus(1'b0, 4'h0, 32'h0000_0000);
      check(q, tb_s[i]);
      bus(1'b0, 4'h4, 32'h0000_0000);
      check(q, {24'h00_0000, tb_b[i]});
      bus(1'b0, 4'h0, 32'h0000_0000);
      check(q, 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
      $display("test %0d done", i);
    end
    bus(1'b1, 4'h8, 32'h0000_0021);
    send(8'h66, 2'h0);
    check(32'(irq), 32'h0000_0000);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(q, 32'h0000_0020);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(q, 32'h0000_0066);
    $display("test mask done");
    send(8'h99, 2'h0);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(q, 32'h0000_0099);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(q, 32'h0000_0020);
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(q, 32'h0000_0099);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("test order done");
    summarize();
  end
endmodule
